// file: design/pwdt_top.v
`timescale 1ns/100ps
`include "pwdt_defines.vh"

module pwdt_top
(
  input wire i_clock,
  input wire i_reset,
  input wire i_hw_power_down_input_n,
  input wire i_powersave_enable_autostart_pin,
  input wire i_osc_power_on_reset,
  input wire i_osc_watchdog_reset,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [7:0] o_rdata,
  output wire o_watchdog_reset,
  output wire o_powersave_allowed,
  output wire o_idle_mode,
  output wire o_power_down_mode,
  output wire o_slow_mode
);

  // ===================================================================
  // State
  reg [7:0] watchdog_reload_reg_r;
  reg refresh_arm_flag_r;
  reg [1:0] arm_age_r;
  reg watchdog_start_flag_r;
  reg watchdog_reset_status_r;
  reg [6:0] interrupt_enable_first_other_r;
  reg [6:0] interrupt_enable_second_other_r;
  reg [6:0] ip0_other_r;
  reg [2:0] psave_r;
  reg running_r;
  reg [14:0] count_r;
  reg [4:0] div_base_r;
  reg [3:0] div_extra_r;
  reg [7:0] rst_cnt_r;
  reg hw_reset_seen_r;

  wire hw_pd_active = ~i_hw_power_down_input_n;
  wire ext_reset = i_reset | hw_pd_active;
  wire strap_high = i_powersave_enable_autostart_pin;
  wire wd_reset_active = (rst_cnt_r != 8'h00);
  wire any_reset = ext_reset | i_osc_power_on_reset | wd_reset_active;
  wire psel = watchdog_reload_reg_r[`PWDT_BIT_PSEL];

  function is_wr;
    input [7:0] a;
    begin
      is_wr = i_write && (i_addr == a);
    end
  endfunction

  wire wr_reload = is_wr(`PWDT_ADDR_RELOAD);
  wire wr_interrupt_enable_first = is_wr(`PWDT_ADDR_INTERRUPT_ENABLE_FIRST);
  wire wr_interrupt_enable_second = is_wr(`PWDT_ADDR_INTERRUPT_ENABLE_SECOND);
  wire wr_ip0 = is_wr(`PWDT_ADDR_IP0);
  wire wr_ctrl = is_wr(`PWDT_ADDR_CTRL);
  wire set_arm = wr_interrupt_enable_first && i_wdata[`PWDT_BIT_FLAG];
  wire set_start = wr_interrupt_enable_second && i_wdata[`PWDT_BIT_FLAG];
  // Refresh needs the arm flag still pending from the prior write.
  wire do_refresh = running_r && set_start && refresh_arm_flag_r;
  wire sw_start = !running_r && set_start;
  wire sleep_entry = wr_ctrl &&
    (i_wdata[`PWDT_BIT_IDLE] | i_wdata[`PWDT_BIT_PDOWN]) && !strap_high;

  // ===================================================================
  // Prescalers: divide by 24 always, and by a further 16 (384 in all) when selected.
  wire base_tick = (div_base_r == `PWDT_DIV_BASE);
  wire count_tick = base_tick &&
    (!psel || (div_extra_r == `PWDT_DIV_EXTRA));

  // ===================================================================
  // Counter control
  wire stop_now = (i_reset && !strap_high) || hw_pd_active ||
    i_osc_watchdog_reset || sleep_entry;
  // Hardware start is taken while reset is held, or on the first edge after power-down ends.
  // A reset with the strap high restarts a running timer at the default.
  wire hw_start = (ext_reset || hw_reset_seen_r) && strap_high;
  wire overflow = running_r && (count_r == `PWDT_OVF_STATE) &&
    !wd_reset_active;

  // ===================================================================
  // Hardware start memory
  // The stop condition wins while power-down is active, so a strapped
  // start is remembered for the first cycle after the input is released.
  always @(posedge i_clock)
  begin
    hw_reset_seen_r <= hw_pd_active && strap_high;
  end

  always @(posedge i_clock)
  begin
    if (i_reset && !strap_high)
    begin
      running_r <= 1'b0;
      count_r <= 15'h0000;
    end
    else if (stop_now)
    begin
      running_r <= 1'b0;
    end
    else if (hw_start || sw_start || do_refresh)
    begin
      running_r <= 1'b1;
      // A hardware start always loads zero, whatever the reload register holds.
      count_r <= {(hw_start ? 7'h00 : watchdog_reload_reg_r[6:0]),
        8'h00};
    end
    else if (running_r && count_tick && !overflow)
    begin
      count_r <= count_r + 15'h0001;
    end
    else if (overflow)
    begin
      // Step past the terminal state at once, in the same cycle the reset pulse is loaded.
      count_r <= count_r + 15'h0001;
    end
  end

  always @(posedge i_clock)
  begin
    if (i_reset || !running_r || hw_start || sw_start || do_refresh)
    begin
      div_base_r <= 5'd0;
      div_extra_r <= 4'h0;
    end
    else
    begin
      // Restarting the dividers on every start keeps each timeout full.
      div_base_r <= base_tick ? 5'd0 : div_base_r + 5'd1;
      if (base_tick)
      begin
        div_extra_r <= div_extra_r + 4'h1;
      end
    end
  end

  // ===================================================================
  // Watchdog reset pulse
  always @(posedge i_clock)
  begin
    if (i_reset || hw_pd_active)
    begin
      rst_cnt_r <= 8'h00;
    end
    else if (overflow)
    begin
      rst_cnt_r <= psel ? `PWDT_RST_LONG : `PWDT_RST_SHORT;
    end
    else if (wd_reset_active)
    begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
    end
  end

  assign o_watchdog_reset = wd_reset_active;

  // ===================================================================
  // Flags and registers
  always @(posedge i_clock)
  begin
    if (any_reset || i_osc_watchdog_reset)
    begin
      // The watchdog pulse clears the system but not the timer or status; i_osc_watchdog_reset also stops the timer.
      watchdog_reload_reg_r <= `PWDT_RELOAD_RST;
      refresh_arm_flag_r <= 1'b0;
      arm_age_r <= 2'd0;
      watchdog_start_flag_r <= 1'b0;
      interrupt_enable_first_other_r <= 7'h00;
      interrupt_enable_second_other_r <= 7'h00;
      ip0_other_r <= 7'h00;
      psave_r <= 3'b000;
    end
    else
    begin
      if (wr_reload)
      begin
        watchdog_reload_reg_r <= i_wdata;
      end
      if (set_arm)
      begin
        refresh_arm_flag_r <= 1'b1;
        arm_age_r <= 2'd0;
      end
      else if (refresh_arm_flag_r)
      begin
        arm_age_r <= arm_age_r + 2'd1;
        if (arm_age_r + 2'd1 == `PWDT_ARM_CYCLES)
        begin
          refresh_arm_flag_r <= 1'b0;
        end
      end
      if (wr_interrupt_enable_first)
      begin
        interrupt_enable_first_other_r <= {i_wdata[7], i_wdata[5:0]};
      end
      if (wr_interrupt_enable_second)
      begin
        interrupt_enable_second_other_r <= {i_wdata[7], i_wdata[5:0]};
        watchdog_start_flag_r <= i_wdata[`PWDT_BIT_FLAG] | running_r;
      end
      if (wr_ip0)
      begin
        ip0_other_r <= {i_wdata[7], i_wdata[5:0]};
      end
      if (wr_ctrl)
      begin
        psave_r <= strap_high ? 3'b000 : i_wdata[2:0];
      end
      else if (strap_high)
      begin
        psave_r <= 3'b000;
      end
    end
  end

  always @(posedge i_clock)
  begin
    // The overflow wins over a software write in the same cycle.
    if (i_reset || hw_pd_active)
    begin
      watchdog_reset_status_r <= 1'b0;
    end
    else if (overflow)
    begin
      watchdog_reset_status_r <= 1'b1;
    end
    else if (wr_ip0)
    begin
      watchdog_reset_status_r <= i_wdata[`PWDT_BIT_FLAG];
    end
  end

  assign o_powersave_allowed = !strap_high;
  assign o_idle_mode = psave_r[`PWDT_BIT_IDLE];
  assign o_power_down_mode = psave_r[`PWDT_BIT_PDOWN];
  assign o_slow_mode = psave_r[`PWDT_BIT_SLOW];

  // ===================================================================
  // Read port
  reg [7:0] rdata_nxt;

  always @*
  begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `PWDT_ADDR_RELOAD: rdata_nxt = watchdog_reload_reg_r;
      `PWDT_ADDR_INTERRUPT_ENABLE_FIRST: rdata_nxt = {interrupt_enable_first_other_r[6],
        refresh_arm_flag_r, interrupt_enable_first_other_r[5:0]};
      `PWDT_ADDR_INTERRUPT_ENABLE_SECOND: rdata_nxt = {interrupt_enable_second_other_r[6],
        watchdog_start_flag_r, interrupt_enable_second_other_r[5:0]};
      `PWDT_ADDR_IP0: rdata_nxt = {ip0_other_r[6],
        watchdog_reset_status_r, ip0_other_r[5:0]};
      `PWDT_ADDR_CTRL: rdata_nxt = {running_r, 4'h0, psave_r};
      `PWDT_ADDR_COUNT: rdata_nxt = {1'b0, count_r[14:8]};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand for one cycle only, so an idle port reads as zero.
  always @(posedge i_clock)
  begin
    if (i_reset || !i_read)
    begin
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule

// file: include/pwdt_defines.vh
`ifndef PWDT_DEFINES_VH
`define PWDT_DEFINES_VH
// =====================================================================
// Register map
`define PWDT_ADDR_RELOAD 8'h86
`define PWDT_ADDR_INTERRUPT_ENABLE_FIRST 8'ha8
`define PWDT_ADDR_INTERRUPT_ENABLE_SECOND 8'hb8
`define PWDT_ADDR_IP0 8'ha9
`define PWDT_ADDR_CTRL 8'hf0
`define PWDT_ADDR_COUNT 8'hf1
// =====================================================================
// Field positions and reset values
`define PWDT_BIT_FLAG 6
`define PWDT_BIT_PSEL 7
`define PWDT_BIT_IDLE 0
`define PWDT_BIT_PDOWN 1
`define PWDT_BIT_SLOW 2
`define PWDT_RELOAD_RST 8'h00
// =====================================================================
// Timing
`define PWDT_DIV_BASE 5'd23
`define PWDT_DIV_EXTRA 4'hf
`define PWDT_OVF_STATE 15'h7ffc
`define PWDT_RST_SHORT 8'd8
`define PWDT_RST_LONG 8'd128
`define PWDT_ARM_CYCLES 2'd2
`endif

// file: tb/pwdt_chk_sva.sv
`timescale 1ns/100ps
// ====
// Port checker.
module pwdt_chk
(
  input wire i_clock,
  input wire i_reset,
  input wire i_powersave_enable_autostart_pin,
  input wire i_osc_power_on_reset,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_write,
  input wire i_read,
  input wire [7:0] o_rdata,
  input wire o_watchdog_reset,
  input wire o_powersave_allowed,
  input wire o_idle_mode,
  input wire o_power_down_mode,
  input wire o_slow_mode
);
  wire strap = i_powersave_enable_autostart_pin;
  reg psel_r;
  // The reload clears when the pulse starts, so the length follows the
  // select bit held just before it.
  always @(posedge i_clock)
    if (i_reset || i_osc_power_on_reset || o_watchdog_reset)
      psel_r <= 1'b0;
    else if (i_write && i_addr == 8'h86)
      psel_r <= i_wdata[7];
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_strap_power: assert property (o_powersave_allowed == !strap)
    else $error("power save allow wrong");
  a_sleep_block: assert property (strap && i_write && i_addr == 8'hf0
    |=> !$rose(o_idle_mode) && !$rose(o_power_down_mode)
    && !$rose(o_slow_mode)) else $error("sleep mode entered");
  a_mode_follow: assert property (!strap && i_write && i_addr == 8'hf0
    |=> {o_slow_mode, o_power_down_mode, o_idle_mode}
    == $past(i_wdata[2:0])) else $error("mode bits wrong");
  a_rdata_quiet: assert property (!$past(i_read) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_rd: assert property ($past(i_read) && $past(i_addr) == 8'h00
    |-> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_pulse_short: assert property ($rose(o_watchdog_reset) && !psel_r
    |-> o_watchdog_reset[*8] ##1 !o_watchdog_reset)
    else $error("short pulse length wrong");
  a_pulse_gap: assert property ($fell(o_watchdog_reset)
    |-> !o_watchdog_reset[*8]) else $error("pulse restarted");
  a_reset_quiet: assert property (disable iff (1'b0) $past(i_reset)
    |-> !o_watchdog_reset && !o_idle_mode && !o_power_down_mode
    && !o_slow_mode) else $error("outputs active in reset");
endmodule
bind pwdt_top pwdt_chk i_chk(.i_clock(i_clock), .i_reset(i_reset),
  .i_powersave_enable_autostart_pin(i_powersave_enable_autostart_pin),
  .i_osc_power_on_reset(i_osc_power_on_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
  .o_rdata(o_rdata), .o_watchdog_reset(o_watchdog_reset),
  .o_powersave_allowed(o_powersave_allowed), .o_idle_mode(o_idle_mode),
  .o_power_down_mode(o_power_down_mode), .o_slow_mode(o_slow_mode));

// file: tb/programmable_watchdog_timer_tb.sv
`timescale 1ns/100ps
module programmable_watchdog_timer_tb;
  reg i_clock, i_reset, hpd_n, strap, por, owr, i_write, i_read;
  reg [7:0] i_addr, i_wdata;
  wire [7:0] o_rdata;
  wire wdr, idle;
  integer errors = 0, n_tests = 0, n, m;
  pwdt_top i_dut(.i_clock(i_clock), .i_reset(i_reset),
    .i_hw_power_down_input_n(hpd_n),
    .i_powersave_enable_autostart_pin(strap), .i_osc_power_on_reset(por),
    .i_osc_watchdog_reset(owr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .o_watchdog_reset(wdr), .o_powersave_allowed(), .o_idle_mode(idle),
    .o_power_down_mode(), .o_slow_mode());
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ====
  // Access tasks.
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      errors = errors + 1;
    end
  endtask
  task nop(input integer c);
    i_write <= 1'b0;
    i_read <= 1'b0;
    repeat (c) @(posedge i_clock);
  endtask
  // The strobe stays up so that two writes can sit in adjacent cycles.
  task wr(input [7:0] a, input [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    i_addr <= a;
    i_write <= 1'b0;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    chk("read data", e, o_rdata);
    @(posedge i_clock);
  endtask
  task rst(input s);
    strap <= s;
    i_reset <= 1'b1;
    nop(3);
    i_reset <= 1'b0;
    nop(2);
  endtask
  task close_out;
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #2000000;
    errors = errors + 1;
    close_out;
  end
  // ====
  // Tests.
  initial
  begin
    {i_reset, hpd_n, strap, por, owr, i_write, i_read} = 7'b1100000;
    {i_addr, i_wdata} = 16'h0000;
    rst(1'b0);
    rd(8'hf0, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h86, 8'h7e); rd(8'h86, 8'h7e);
    wr(8'hb8, 8'h40); nop(1); rd(8'hf0, 8'h80);
    rd(8'hf1, 8'h7e);
    nop(256 * 24 + 30); rd(8'hf1, 8'h7f);
    wr(8'ha8, 8'h40); nop(3); wr(8'hb8, 8'h40); nop(1);
    rd(8'ha8, 8'h00);
    rd(8'hf1, 8'h7f);
    wr(8'h86, 8'h7e);
    wr(8'ha8, 8'h40); wr(8'hb8, 8'h40); nop(1);
    rd(8'hf1, 8'h7e);
    n = 0;
    while (!wdr && n < 13000)
    begin
      @(posedge i_clock);
      n = n + 1;
    end
    chk("timeout", 8'h01, {7'h00, n > 12100 && n < 12250});
    m = 0;
    while (wdr && m < 200)
    begin
      m = m + 1;
      @(posedge i_clock);
    end
    chk("pulse", 8'h08, m[7:0]);
    rd(8'ha9, 8'h40); rd(8'hf0, 8'h80);
    rd(8'h86, 8'h00);
    wr(8'ha9, 8'h00); nop(1); rd(8'ha9, 8'h00);
    wr(8'ha9, 8'h40); nop(1); rst(1'b1); rd(8'ha9, 8'h00);
    rd(8'hf0, 8'h80); rd(8'hf1, 8'h00);
    wr(8'hf0, 8'h07); nop(1); rd(8'hf0, 8'h80);
    hpd_n <= 1'b0; nop(2); hpd_n <= 1'b1; strap <= 1'b0; nop(2);
    rd(8'hf0, 8'h00);
    strap <= 1'b1; nop(2); rd(8'hf0, 8'h00);
    strap <= 1'b0; wr(8'hb8, 8'h40); wr(8'hf0, 8'h01); nop(1);
    rd(8'hf0, 8'h01);
    chk("idle", 8'h01, {7'h00, idle});
    wr(8'hf0, 8'h00); wr(8'ha9, 8'h40); wr(8'hb8, 8'h40); nop(1);
    owr <= 1'b1; nop(2); owr <= 1'b0; nop(1);
    rd(8'ha9, 8'h40); rd(8'hf0, 8'h00);
    wr(8'h86, 8'h55); por <= 1'b1; nop(2); por <= 1'b0; nop(1);
    rd(8'h86, 8'h00);
    close_out;
  end
endmodule
